// ---- verilog/dmr_mode_regs.v ----
`timescale 1ns/1ps
`include "dmr_regs.vh"
module dmr_mode_regs #(
    parameter [3:0] DENSITY = 4'h0      // Density code
) (
    input  wire       clock,            // 100 MHz core clock
    input  wire       rst_n,            // Async reset, active low
    input  wire       mr_wr,            // Mode-register write strobe
    input  wire       mr_rd,            // Mode-register read strobe
    input  wire [5:0] mr_addr,          // Mode-register address
    input  wire [7:0] mr_wdata,         // Write operand
    input  wire       setpoint_write_select, // Set-point for access
    input  wire       setpoint_operate_select, // Set-point in use
    input  wire       cal_pin_grounded, // Calibration pin tied to ground
    input  wire       cal_cmd,          // Impedance-calibration command
    output wire [7:0] rd_data,          // Read data on low data lines
    output wire       rd_valid,         // Read data valid pulse
    output wire       impedance_cal_default_restore, // Restore default pulse
    output wire       cal_start,        // Calibration start pulse
    output wire [2:0] data_bus_termination, // Applied data termination
    output wire [2:0] cmd_bus_termination,  // Applied command termination
    output wire [5:0] cmd_ref_level,    // Applied reference level
    output wire       cmd_ref_range_select // Applied reference range
);
    reg        pin_s1_q, pin_s2_q;
    // Address decode flags
    reg        hit_info;
    reg        hit_zq;
    reg        hit_term;
    reg        hit_vref;
    reg        hit_rsvd;
    // Output flops and their next values
    reg  [7:0] rd_data_q;
    reg  [7:0] rd_data_d;
    reg        rd_valid_q;
    reg        rd_valid_d;
    reg        restore_q;
    reg        restore_d;
    reg        cal_start_q;
    reg        cal_start_d;
    reg  [2:0] dq_term_q;
    reg  [2:0] dq_term_d;
    reg  [2:0] ca_term_q;
    reg  [2:0] ca_term_d;
    reg  [5:0] ref_level_q;
    reg  [5:0] ref_level_d;
    reg        ref_range_q;
    reg        ref_range_d;
    wire       wr_term = mr_wr && hit_term;
    wire       wr_vref = mr_wr && hit_vref;
    wire [2:0] dq_in   = mr_wdata[`DMR_TERM_DQ_LSB +: 3];
    wire [2:0] ca_in   = mr_wdata[`DMR_TERM_CA_LSB +: 3];
    wire       dq_ok   = dq_in != `DMR_TERM_RSVD;
    wire       ca_ok   = ca_in != `DMR_TERM_RSVD;
    wire       vref_ok = mr_wdata[5:0] <= `DMR_VREF_MAX;
    wire [2:0] dq_rd, dq_act, ca_rd, ca_act;
    wire [6:0] vr_rd, vr_act;
    wire [7:0] info    = {`DMR_INFO_WIDTH, DENSITY, `DMR_INFO_TYPE};

    // Reserved codes are dropped so the applied field never holds them
    dmr_setpoint_pair #(.W(3), .RST(`DMR_TERM_RESET)) u_dq (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (wr_term && dq_ok),
        .wr_data (dq_in),
        .wr_sel  (setpoint_write_select),
        .op_sel  (setpoint_operate_select),
        .rd_data (dq_rd),
        .act_data(dq_act)
    );
    dmr_setpoint_pair #(.W(3), .RST(`DMR_TERM_RESET)) u_ca (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (wr_term && ca_ok),
        .wr_data (ca_in),
        .wr_sel  (setpoint_write_select),
        .op_sel  (setpoint_operate_select),
        .rd_data (ca_rd),
        .act_data(ca_act)
    );
    // Range always stored; level only when in the valid code span
    dmr_setpoint_pair #(.W(7), .RST({`DMR_RANGE_RESET, `DMR_VREF_RESET})) u_vr (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (wr_vref),
        .wr_data ({mr_wdata[`DMR_RANGE_BIT], vref_ok ? mr_wdata[5:0] : vr_rd[5:0]}),
        .wr_sel  (setpoint_write_select),
        .op_sel  (setpoint_operate_select),
        .rd_data (vr_rd),
        .act_data(vr_act)
    );

    // Pin is asynchronous; only the second stage is read
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= cal_pin_grounded;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Decoded once so read mux, pulses and field writes agree on every address
    always @* begin
        hit_info = 1'b0;
        hit_zq   = 1'b0;
        hit_term = 1'b0;
        hit_vref = 1'b0;
        hit_rsvd = 1'b0;
        case (mr_addr)
            `DMR_ADDR_INFO: begin
                hit_info = 1'b1;
            end
            `DMR_ADDR_RSVD_B: begin
                hit_rsvd = 1'b1;
            end
            `DMR_ADDR_ZQRST: begin
                hit_zq = 1'b1;
            end
            `DMR_ADDR_TERM: begin
                hit_term = 1'b1;
            end
            `DMR_ADDR_VREF: begin
                hit_vref = 1'b1;
            end
            default: begin
                hit_rsvd = (mr_addr >= `DMR_ADDR_RSVD_LO) &&
                           (mr_addr <= `DMR_ADDR_RSVD_HI);
            end
        endcase
    end

    // Write-only and reserved addresses read zero, so a read never has side effects
    always @* begin
        rd_valid_d = mr_rd;
        rd_data_d  = 8'h00;
        if (mr_rd) begin
            if (hit_info) begin
                rd_data_d = info;
            end else if (hit_vref) begin
                rd_data_d = {1'b0, vr_rd};
            end else if (hit_rsvd) begin
                rd_data_d = 8'h00;
            end
        end
    end

    // A grounded calibration pin blocks calibration starts, not the default restore
    always @* begin
        restore_d   = mr_wr && hit_zq && mr_wdata[0];
        cal_start_d = cal_cmd && !pin_s2_q;
    end

    // Only the operate-selected copies ever reach the applied outputs
    always @* begin
        dq_term_d   = dq_act;
        ca_term_d   = ca_act;
        ref_level_d = vr_act[5:0];
        ref_range_d = vr_act[`DMR_RANGE_BIT];
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            restore_q   <= 1'b0;
            cal_start_q <= 1'b0;
        end else begin
            restore_q   <= restore_d;
            cal_start_q <= cal_start_d;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dq_term_q   <= `DMR_TERM_RESET;
            ca_term_q   <= `DMR_TERM_RESET;
            ref_level_q <= `DMR_VREF_RESET;
            ref_range_q <= `DMR_RANGE_RESET;
        end else begin
            dq_term_q   <= dq_term_d;
            ca_term_q   <= ca_term_d;
            ref_level_q <= ref_level_d;
            ref_range_q <= ref_range_d;
        end
    end

    // Ports come straight from the flops above
    assign rd_data                       = rd_data_q;
    assign rd_valid                      = rd_valid_q;
    assign impedance_cal_default_restore = restore_q;
    assign cal_start                     = cal_start_q;
    assign data_bus_termination          = dq_term_q;
    assign cmd_bus_termination           = ca_term_q;
    assign cmd_ref_level                 = ref_level_q;
    assign cmd_ref_range_select          = ref_range_q;
endmodule

// ---- verilog/dmr_regs.vh ----
`ifndef DMR_REGS_VH
`define DMR_REGS_VH
`define DMR_ADDR_RSVD_LO   6'h05
`define DMR_ADDR_RSVD_HI   6'h07
`define DMR_ADDR_INFO      6'h08
`define DMR_ADDR_RSVD_B    6'h09
`define DMR_ADDR_ZQRST     6'h0a
`define DMR_ADDR_TERM      6'h0b
`define DMR_ADDR_VREF      6'h0c
`define DMR_INFO_TYPE      2'h0
`define DMR_INFO_WIDTH     2'h0
`define DMR_TERM_DQ_LSB    0
`define DMR_TERM_CA_LSB    4
`define DMR_TERM_RSVD      3'h7
`define DMR_TERM_RESET     3'h0
`define DMR_VREF_MAX       6'h32
`define DMR_VREF_RESET     6'h1d
`define DMR_RANGE_RESET    1'h1
`define DMR_RANGE_BIT      6
`endif

// ---- verilog/dmr_setpoint_pair.v ----
`timescale 1ns/1ps
// Two set-point copies of one field; write/read by write-select, apply by operate-select
module dmr_setpoint_pair #(
    parameter       W   = 3,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input  wire         clock,      // Core clock
    input  wire         rst_n,      // Async reset, active low
    input  wire         wr_en,      // Write this field
    input  wire [W-1:0] wr_data,    // New value
    input  wire         wr_sel,     // Write-select set point
    input  wire         op_sel,     // Operate-select set point
    output wire [W-1:0] rd_data,    // Copy chosen by write-select
    output wire [W-1:0] act_data    // Copy chosen by operate-select
);
    reg [W-1:0] copy_q [0:1];
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_copy
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n)
                    copy_q[i] <= RST;
                else if (wr_en && (wr_sel == (i != 0)))
                    copy_q[i] <= wr_data;
            end
        end
    endgenerate
    assign rd_data  = copy_q[wr_sel];
    assign act_data = copy_q[op_sel];
endmodule

// ---- bench/dmr_chk.sv ----
`timescale 1ns/1ps
module dmr_chk (
    input wire       clock,                         // Core clock
    input wire       rst_n,                         // Async reset, active low
    input wire       mr_wr,                         // Write strobe
    input wire       mr_rd,                         // Read strobe
    input wire       cal_cmd,                       // Calibration command
    input wire       cal_pin_grounded,              // Calibration pin grounded
    input wire       setpoint_write_select,         // Set point for access
    input wire       setpoint_operate_select,       // Set point in use
    input wire [5:0] mr_addr,                       // Address
    input wire [7:0] mr_wdata,                      // Operand
    input wire [7:0] rd_data,                       // Read data
    input wire       rd_valid,                      // Read valid pulse
    input wire       impedance_cal_default_restore, // Restore pulse
    input wire       cal_start,                     // Calibration start pulse
    input wire [2:0] data_bus_termination           // Applied data termination
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire info = mr_rd && mr_addr == 6'h08;
    wire zq = mr_wr && mr_addr == 6'h0a && mr_wdata[0];
    sequence s_wr;
        mr_wr && mr_addr == 6'h0b && mr_wdata[2:0] != 3'h7
            && setpoint_write_select == setpoint_operate_select;
    endsequence
    sequence s_hold;
        !mr_wr && $stable(setpoint_operate_select);
    endsequence
    a_rd_valid: assert property (mr_rd |=> rd_valid)
        else $error("valid");
    a_info_type: assert property (info |=> rd_data[1:0] == 2'h0)
        else $error("type");
    a_info_density: assert property (info |=> rd_data[5:2] <= 4'h3)
        else $error("density");
    a_info_width: assert property (info |=> rd_data[7:6] == 2'h0)
        else $error("width");
    a_rsvd_zero: assert property (mr_rd && mr_addr inside {[5:7], 9, 10, 11} |=> !rd_data)
        else $error("reserved");
    a_rd_idle: assert property (!mr_rd |=> rd_data == 8'h00 && !rd_valid)
        else $error("idle read");
    a_cal_restore: assert property (zq |=> impedance_cal_default_restore)
        else $error("restore");
    a_restore_cause: assert property (!zq |=> !impedance_cal_default_restore)
        else $error("stray restore");
    a_ground_ignore: assert property (cal_pin_grounded[*4] ##0 cal_cmd |=> !cal_start)
        else $error("cal");
    a_term_apply: assert property (s_wr ##1 s_hold |=>
        data_bus_termination == $past(mr_wdata[2:0], 2)) else $error("term");
endmodule
bind dmr_mode_regs dmr_chk u_chk (.clock, .rst_n, .mr_wr, .mr_rd, .cal_cmd, .cal_pin_grounded,
    .setpoint_write_select, .setpoint_operate_select, .mr_addr, .mr_wdata, .rd_data, .rd_valid,
    .impedance_cal_default_restore, .cal_start, .data_bus_termination);

// ---- bench/dmr_ctrl_model.sv ----
`timescale 1ns/1ps
module dmr_ctrl_model (
    input  wire       clock,   // Core clock
    output reg        mr_wr,   // Write strobe
    output reg        mr_rd,   // Read strobe
    output reg  [5:0] mr_addr, // Address
    output reg  [7:0] mr_wdata // Operand
);
    initial {mr_wr, mr_rd, mr_addr, mr_wdata} = 16'h0000;
    task automatic access(input bit wr, input [5:0] a, input [7:0] d);
        @(negedge clock);
        {mr_wr, mr_rd, mr_addr, mr_wdata} = {wr, !wr, a, d};
        @(negedge clock);
        {mr_wr, mr_rd, mr_addr, mr_wdata} = {2'b00, ~a, ~d}; // Released bus shows no old value
    endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    localparam [3:0] DENS = 4'h3;
    reg clock = 0, rst_n = 0, ws = 0, os = 0, gnd = 0, cal_cmd = 0;
    wire wr, rd, vld, rst_pl, cal_start, rng;
    wire [5:0] ad, lvl;
    wire [7:0] wd, rdd;
    wire [2:0] dt, ct;
    int bad_count = 0, cmp_count = 0, i, a, d, td[2], tc[2], lv[2], rg[2];
    initial forever #5 clock = ~clock;
    dmr_ctrl_model i_ctrl (.clock(clock), .mr_wr(wr), .mr_rd(rd), .mr_addr(ad), .mr_wdata(wd));
    dmr_mode_regs #(.DENSITY(DENS)) i_dut (.clock(clock), .rst_n(rst_n), .mr_wr(wr),
        .mr_rd(rd), .mr_addr(ad), .mr_wdata(wd), .setpoint_write_select(ws),
        .setpoint_operate_select(os), .cal_pin_grounded(gnd), .cal_cmd(cal_cmd),
        .rd_data(rdd), .rd_valid(vld), .impedance_cal_default_restore(rst_pl),
        .cal_start(cal_start), .data_bus_termination(dt), .cmd_bus_termination(ct),
        .cmd_ref_level(lvl), .cmd_ref_range_select(rng));
    task chk(input [7:0] seen, input [7:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task applied;
        repeat (3) @(negedge clock);
        chk(dt, td[os], "dterm");
        chk(ct, tc[os], "cterm");
        chk(lvl, lv[os], "level");
        chk(rng, rg[os], "range");
    endtask
    task do_reset;
        rst_n = 0;
        repeat (5) @(negedge clock);
        rst_n = 1;
        td = '{0, 0};
        tc = '{0, 0};
        lv = '{29, 29};
        rg = '{1, 1};
        applied;
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        i = $urandom(45648);
        do_reset;
        for (i = 0; i < 60; i++) begin
            a = $urandom_range(12, 5);
            d = $urandom_range(255, 0);
            ws = $urandom_range(1, 0);
            os = $urandom_range(1, 0);
            if (!(a inside {[5:7], 9})) begin
                i_ctrl.access(1, a[5:0], d[7:0]);
                chk(rst_pl, a == 10 && d[0], "restore");
            end
            if (a == 11 && d[2:0] != 7) td[ws] = d[2:0];
            if (a == 11 && d[6:4] != 7) tc[ws] = d[6:4];
            if (a == 12 && d[5:0] <= 50) lv[ws] = d[5:0];
            if (a == 12) rg[ws] = d[6];
            applied;
            i_ctrl.access(0, a[5:0], 8'h5a);
            chk(rdd, a == 8 ? DENS * 4 : a == 12 ? rg[ws] * 64 + lv[ws] : 0, "read");
            chk(vld, 1, "valid");
        end
        i_ctrl.access(1, 6'h0a, 8'h01);
        chk(rst_pl, 1, "restore");
        @(negedge clock);
        chk(rst_pl, 0, "restore end");
        for (i = 0; i < 2; i++) begin
            gnd = i;
            repeat (4) @(negedge clock);
            cal_cmd = 1;
            @(negedge clock);
            cal_cmd = 0;
            chk(cal_start, !gnd, "cal");
        end
        do_reset;
        print_verdict;
    end
endmodule
